/* File: hdl/ufc_addr.sv */
`default_nettype none
module ufc_addr (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control link
  ufc_if.addr_side lk
);
  import ufc_pkg::*;

  logic [UFC_FA_W-1:0] act_ff;  // Address used for matching
  logic [UFC_FA_W-1:0] new_ff;  // Address waiting for transfer end
  logic pend_ff;                // Waiting flag

  // Written address is parked until the transfer ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_ff <= UFC_FA_RST;
      new_ff <= UFC_FA_RST;
      pend_ff <= 1'b0;
    end else if (lk.bus_rst) begin
      // Bus reset drops the address at once
      act_ff <= UFC_FA_RST;
      new_ff <= UFC_FA_RST;
      pend_ff <= 1'b0;
    end else if (lk.wr_addr) begin
      new_ff <= lk.wr_data;
      pend_ff <= 1'b1;
    end else if (pend_ff && lk.xfer_done) begin
      act_ff <= new_ff;
      pend_ff <= 1'b0;
    end
  end

  assign lk.act_addr = act_ff;
  assign lk.new_addr = new_ff;
  assign lk.pending = pend_ff;
endmodule
`default_nettype wire

/* File: hdl/ufc_if.sv */
`default_nettype none
interface ufc_if #(parameter int N_EP = 3);
  // Address side
  logic wr_addr;            // Software wrote the address register
  logic [6:0] wr_data;      // Written address
  logic xfer_done;          // Current transfer finished
  logic bus_rst;            // Bus reset edge
  logic [6:0] act_addr;     // Address in force
  logic [6:0] new_addr;     // Last written address
  logic pending;            // New address not yet in force
  // Iso side
  logic iso_gate;           // Hold iso packets until frame start
  logic sof;                // Frame start
  logic [N_EP-1:0] is_iso;  // Endpoint is isochronous IN
  logic [N_EP-1:0] loaded;  // Packet loaded into endpoint
  logic [N_EP-1:0] held;    // Packet held back
  modport ctl (output wr_addr, wr_data, xfer_done, bus_rst, iso_gate, sof, is_iso, loaded,
    input act_addr, new_addr, pending, held);
  modport addr_side (input wr_addr, wr_data, xfer_done, bus_rst,
    output act_addr, new_addr, pending);
  modport iso_side (input iso_gate, sof, is_iso, loaded, bus_rst, output held);
endinterface
`default_nettype wire

/* File: hdl/ufc_iso.sv */
`default_nettype none
module ufc_iso #(
  parameter int N_EP = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control link
  ufc_if.iso_side lk
);
  import ufc_pkg::*;

  logic [N_EP-1:0] held_ff;  // One hold bit per IN endpoint

  // An iso packet loaded while the gate is on waits for the next frame start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_ff <= '0;
    end else if (lk.bus_rst || lk.sof) begin
      // Frame start releases every held packet
      held_ff <= '0;
    end else if (lk.iso_gate) begin
      held_ff <= held_ff | (lk.loaded & lk.is_iso);
    end
  end

  assign lk.held = held_ff;
endmodule
`default_nettype wire

/* File: hdl/ufc_pkg.sv */
`default_nettype none
package ufc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [5:0] UFC_OFS_FUNCTION_ADDRESS_REG = 6'h00;   // Function address
  localparam logic [5:0] UFC_OFS_POWER = 6'h01;   // Device power control
  localparam logic [5:0] UFC_OFS_IRQ_FLAG = 6'h06; // Common event flags, clear on read
  localparam logic [5:0] UFC_OFS_IRQ_EN = 6'h0b;   // Common event enables

  // ****************************************
  // Power register fields
  // ****************************************
  localparam int UFC_PWR_SUSPEND_DETECT_ENABLE = 0;   // Suspend detect enable
  localparam int UFC_PWR_SUSPEND_STATUS = 1;   // Suspend status
  localparam int UFC_PWR_RESUME = 2;  // Remote wakeup drive
  localparam int UFC_PWR_BUSRST = 3;  // Bus reset status / soft reset
  localparam int UFC_PWR_INHIBIT = 4; // Block inhibit
  localparam int UFC_PWR_ISO = 7;     // Iso update gate

  // ****************************************
  // Address register fields
  // ****************************************
  localparam int UFC_FA_PEND = 7;     // Address pending flag
  localparam int UFC_FA_W = 7;        // Address width

  // ****************************************
  // Event flag fields
  // ****************************************
  localparam int UFC_EV_SUSPEND = 0;
  localparam int UFC_EV_RESUME = 1;
  localparam int UFC_EV_RESET = 2;
  localparam int UFC_EV_SOF = 3;
  localparam int UFC_EV_W = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [UFC_FA_W-1:0] UFC_FA_RST = 7'h00;
  localparam logic [UFC_EV_W-1:0] UFC_EV_EN_RST = 4'he;     // Suspend off
  localparam logic [UFC_EV_W-1:0] UFC_EV_EN_BUSRST = 4'he;  // All but suspend
endpackage
`default_nettype wire

/* File: hdl/ufc_top.sv */
`default_nettype none
module ufc_top
  import ufc_pkg::*;
#(
  parameter int N_EP = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Bus events from the transceiver side
  input wire logic bus_reset_det,
  input wire logic suspend_det,
  input wire logic resume_det,
  input wire logic sof_pulse,
  input wire logic xfer_done,
  // Isochronous IN endpoints
  input wire logic [N_EP-1:0] ep_is_iso,
  input wire logic [N_EP-1:0] ep_pkt_loaded,
  input wire logic in_token,
  input wire logic [1:0] in_token_ep,
  output logic [N_EP-1:0] ep_tx_hold,
  output logic send_zlp,
  // Device level state
  output logic [UFC_FA_W-1:0] func_addr,
  output logic block_enabled,
  output logic suspended,
  output logic resume_drive,
  output logic event_pending,
  // Side effects on neighbouring blocks
  output logic fifo_flush,
  output logic ep_regs_clear,
  output logic usb_rst_n
);

  // ****************************************
  // Soft reset
  // ****************************************

  logic soft_rst_ff;   // One cycle block reset request
  logic blk_rst_n;     // Reset of every block register but soft_rst_ff

  // Self clearing: the request flop itself only sees the pin reset,
  // otherwise it would clear itself asynchronously and glitch
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_rst_ff <= 1'b0;
    end else if (soft_rst_ff) begin
      soft_rst_ff <= 1'b0;
    end else if (reg_wr && reg_addr == UFC_OFS_POWER && reg_wdata[UFC_PWR_BUSRST]) begin
      soft_rst_ff <= 1'b1;
    end
  end

  // Block reset combines pin reset and software request
  assign blk_rst_n = arst_n & ~soft_rst_ff;
  assign usb_rst_n = blk_rst_n;

  // ****************************************
  // Decode
  // ****************************************

  logic wr_power;      // Write to power register
  logic wr_function_address_reg;      // Write to address register
  logic wr_irq_en;     // Write to event enable register
  logic rd_irq_flag;   // Read of event flags

  // Plain address compare, one strobe per register
  always_comb begin
    wr_power = 1'b0;
    wr_function_address_reg = 1'b0;
    wr_irq_en = 1'b0;
    rd_irq_flag = 1'b0;
    if (reg_addr == UFC_OFS_POWER) begin
      wr_power = reg_wr;
    end else if (reg_addr == UFC_OFS_FUNCTION_ADDRESS_REG) begin
      wr_function_address_reg = reg_wr;
    end else if (reg_addr == UFC_OFS_IRQ_EN) begin
      wr_irq_en = reg_wr;
    end else if (reg_addr == UFC_OFS_IRQ_FLAG) begin
      rd_irq_flag = reg_rd;
    end
  end

  // ****************************************
  // Bus reset detection
  // ****************************************

  logic rst_seen_ff;   // Reset signaling seen last cycle
  logic bus_rst_edge;  // Start of reset signaling

  // Side effects fire once at the start, not for the whole reset
  always_ff @(posedge sys_clk or negedge blk_rst_n) begin
    if (!blk_rst_n) begin
      rst_seen_ff <= 1'b0;
    end else begin
      rst_seen_ff <= bus_reset_det;
    end
  end

  assign bus_rst_edge = bus_reset_det & ~rst_seen_ff;
  assign fifo_flush = bus_rst_edge;
  assign ep_regs_clear = bus_rst_edge;

  // ****************************************
  // Power control bits
  // ****************************************

  logic suspend_detect_enable_ff;      // Suspend detect enable
  logic resume_ff;     // Remote wakeup drive
  logic inhibit_ff;    // Block inhibited
  logic iso_gate_ff;   // Iso update gate

  // Plain software bits
  always_ff @(posedge sys_clk or negedge blk_rst_n) begin
    if (!blk_rst_n) begin
      suspend_detect_enable_ff <= 1'b0;
      resume_ff <= 1'b0;
      iso_gate_ff <= 1'b0;
    end else if (wr_power) begin
      suspend_detect_enable_ff <= reg_wdata[UFC_PWR_SUSPEND_DETECT_ENABLE];
      // Software ends the wakeup drive itself after its own delay
      resume_ff <= reg_wdata[UFC_PWR_RESUME];
      iso_gate_ff <= reg_wdata[UFC_PWR_ISO];
    end
  end

  // Inhibit only falls under software; rises only by reset
  always_ff @(posedge sys_clk or negedge blk_rst_n) begin
    if (!blk_rst_n) begin
      inhibit_ff <= 1'b1;
    end else if (wr_power && !reg_wdata[UFC_PWR_INHIBIT]) begin
      inhibit_ff <= 1'b0;
    end
  end

  assign block_enabled = ~inhibit_ff;
  assign resume_drive = resume_ff;

  // ****************************************
  // Suspend state
  // ****************************************

  logic susp_ff;       // In suspend mode
  logic susp_enter;    // Suspend begins this cycle
  logic susp_exit;     // Any reason to leave suspend

  // Exit reasons: resume seen or driven, bus reset; block reset acts via reset
  assign susp_exit = resume_det | resume_ff | bus_reset_det;
  assign susp_enter = suspend_detect_enable_ff & suspend_det & ~susp_ff & ~susp_exit;

  // Exit wins over entry so a reset during suspend never sticks
  always_ff @(posedge sys_clk or negedge blk_rst_n) begin
    if (!blk_rst_n) begin
      susp_ff <= 1'b0;
    end else if (susp_exit) begin
      susp_ff <= 1'b0;
    end else if (susp_enter) begin
      susp_ff <= 1'b1;
    end
  end

  assign suspended = susp_ff;

  // ****************************************
  // Event flags and enables
  // ****************************************

  logic [UFC_EV_W-1:0] ev_en_ff;    // Event enables
  logic [UFC_EV_W-1:0] ev_flag_ff;  // Sticky event flags
  logic [UFC_EV_W-1:0] ev_raw;      // Events this cycle
  logic [UFC_EV_W-1:0] ev_en_now;   // Enables in force for this cycle's events

  // Enables; bus reset forces all on except suspend
  always_ff @(posedge sys_clk or negedge blk_rst_n) begin
    if (!blk_rst_n) begin
      ev_en_ff <= UFC_EV_EN_RST;
    end else if (bus_rst_edge) begin
      ev_en_ff <= UFC_EV_EN_BUSRST | (ev_en_ff & 4'h1);
    end else if (wr_irq_en) begin
      ev_en_ff <= reg_wdata[UFC_EV_W-1:0];
    end
  end

  // The reset event sees the enables as the bus reset leaves them
  assign ev_en_now = bus_rst_edge ? (UFC_EV_EN_BUSRST | (ev_en_ff & 4'h1)) : ev_en_ff;

  // Raw events: suspend entry, detected resume while suspended, reset, frame
  always_comb begin
    ev_raw = '0;
    ev_raw[UFC_EV_SUSPEND] = susp_enter;
    ev_raw[UFC_EV_RESUME] = resume_det & susp_ff;
    ev_raw[UFC_EV_RESET] = bus_rst_edge;
    ev_raw[UFC_EV_SOF] = sof_pulse;
  end

  // Flags: cleared by a read or by bus reset, but a new event wins
  always_ff @(posedge sys_clk or negedge blk_rst_n) begin
    if (!blk_rst_n) begin
      ev_flag_ff <= '0;
    end else if (bus_rst_edge) begin
      ev_flag_ff <= ev_raw & ev_en_now;
    end else if (rd_irq_flag) begin
      ev_flag_ff <= ev_raw & ev_en_now;
    end else begin
      ev_flag_ff <= ev_flag_ff | (ev_raw & ev_en_now);
    end
  end

  assign event_pending = |ev_flag_ff;

  // ****************************************
  // Address and iso submodules
  // ****************************************

  ufc_if #(.N_EP(N_EP)) lk ();

  assign lk.wr_addr = wr_function_address_reg;
  assign lk.wr_data = reg_wdata[UFC_FA_W-1:0];
  assign lk.xfer_done = xfer_done;
  assign lk.bus_rst = bus_rst_edge;
  assign lk.iso_gate = iso_gate_ff;
  assign lk.sof = sof_pulse;
  assign lk.is_iso = ep_is_iso;
  assign lk.loaded = ep_pkt_loaded;

  // Deferred address
  ufc_addr u_addr (
    .clk(sys_clk),
    .rst_n(blk_rst_n),
    .lk(lk.addr_side)
  );

  // Iso hold until frame start
  ufc_iso #(.N_EP(N_EP)) u_iso (
    .clk(sys_clk),
    .rst_n(blk_rst_n),
    .lk(lk.iso_side)
  );

  assign func_addr = lk.act_addr;
  assign ep_tx_hold = lk.held;

  // ****************************************
  // Zero length answer
  // ****************************************

  logic tok_ep_ok;     // Token endpoint number in range
  logic tok_held;      // Token endpoint holds a packet

  // Endpoint numbers 1..N_EP map to hold bits 0..N_EP-1; endpoint zero never iso
  always_comb begin
    tok_ep_ok = (in_token_ep != 2'h0) && (int'(in_token_ep) <= N_EP);
    tok_held = 1'b0;
    if (tok_ep_ok) begin
      tok_held = lk.held[int'(in_token_ep) - 1];
    end
  end

  // Handshake reply; data path sends an empty packet instead of the held one
  assign send_zlp = in_token & iso_gate_ff & tok_held;

  // ****************************************
  // Read data
  // ****************************************

  logic [7:0] rdata_ff;    // Registered read data
  logic [7:0] nxt_rdata;   // Selected read data

  // Unmapped offsets read as zero; bits 6:5 of power read as zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_addr == UFC_OFS_POWER) begin
      nxt_rdata[UFC_PWR_SUSPEND_DETECT_ENABLE] = suspend_detect_enable_ff;
      nxt_rdata[UFC_PWR_SUSPEND_STATUS] = susp_ff;
      nxt_rdata[UFC_PWR_RESUME] = resume_ff;
      nxt_rdata[UFC_PWR_BUSRST] = bus_reset_det;
      nxt_rdata[UFC_PWR_INHIBIT] = inhibit_ff;
      nxt_rdata[UFC_PWR_ISO] = iso_gate_ff;
    end else if (reg_addr == UFC_OFS_FUNCTION_ADDRESS_REG) begin
      nxt_rdata = {lk.pending, lk.new_addr};
    end else if (reg_addr == UFC_OFS_IRQ_FLAG) begin
      nxt_rdata = {4'h0, ev_flag_ff};
    end else if (reg_addr == UFC_OFS_IRQ_EN) begin
      nxt_rdata = {4'h0, ev_en_ff};
    end
  end

  // Data is captured on the read strobe and held until the next read
  always_ff @(posedge sys_clk or negedge blk_rst_n) begin
    if (!blk_rst_n) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule
`default_nettype wire

/* File: verif/ufc_host_model.sv */
`default_nettype none
module ufc_host_model (
  // Clock
  input wire logic clk,
  // Bus events toward the device
  output logic bus_reset_det,
  output logic suspend_det,
  output logic resume_det,
  output logic sof_pulse,
  output logic xfer_done,
  output logic in_token,
  output logic [1:0] in_token_ep
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Host side events
  // ****************************************
  logic [3:0] ev = 4'h0; // Pulses: 0 transfer end, 1 frame, 2 resume, 3 suspend
  assign {suspend_det, resume_det, sof_pulse, xfer_done} = ev;
  initial begin
    bus_reset_det = 1'b0;
    in_token = 1'b0;
    in_token_ep = 2'h0;
  end
  // One-cycle event, launched just after an edge
  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
  endtask
  // Reset signaling is a level that the host holds as long as it likes
  task automatic hold_reset(input logic v);
    @(posedge clk);
    bus_reset_det <= v;
  endtask
  // Endpoint field is scrambled once the token is over, never left stale
  task automatic token(input logic [1:0] e);
    @(posedge clk);
    in_token <= 1'b1;
    in_token_ep <= e;
    @(posedge clk);
    in_token <= 1'b0;
    in_token_ep <= ~e;
  endtask
endmodule
`default_nettype wire

/* File: verif/ufc_top_bench.sv */
`default_nettype none
module ufc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ufc_pkg::*;
  // ****************************************
  // Stimulus and checking
  // ****************************************
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic bus_reset_det, suspend_det, resume_det, sof_pulse, xfer_done, in_token;
  logic [1:0] in_token_ep;
  logic [2:0] ep_is_iso; // Random iso map; the endpoint of the first and last token is always iso
  logic [2:0] ep_pkt_loaded;
  logic [2:0] ep_tx_hold;
  logic send_zlp, block_enabled, suspended, resume_drive, event_pending;
  logic fifo_flush, ep_regs_clear, usb_rst_n;
  logic [6:0] func_addr;
  logic rd_d = 1'b0; // Read taken last edge, data due now
  int err_count = 0;
  int check_count = 0;
  logic [7:0] exp_q[$]; // Expected read data, oldest first
  string name_q[$];
  logic [6:0] adr;
  logic [2:0] iso; // Endpoints made isochronous for the hold scenario
  int i;
  ufc_top #(.N_EP(3)) u_dut (.sys_clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .bus_reset_det, .suspend_det, .resume_det, .sof_pulse, .xfer_done, .ep_is_iso,
    .ep_pkt_loaded, .in_token, .in_token_ep, .ep_tx_hold, .send_zlp, .func_addr,
    .block_enabled, .suspended, .resume_drive, .event_pending, .fifo_flush, .ep_regs_clear,
    .usb_rst_n);
  ufc_host_model u_host (.clk(sys_clk), .bus_reset_det, .suspend_det, .resume_det,
    .sof_pulse, .xfer_done, .in_token, .in_token_ep);
  initial forever #20 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read strobe and its expectation are issued together
  task automatic rd(input logic [5:0] a, input logic [7:0] e, input string n);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    name_q.push_back(n);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
  // Token answer is combinational, so it is looked at inside the token cycle
  task automatic tok(input logic [1:0] e, input logic z);
    fork
      u_host.token(e);
      begin
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("empty packet", {7'h0, z}, {7'h0, send_zlp});
      end
    join
  endtask
  task automatic addr_step;
    adr = 7'(($urandom % 127) + 1);
    wr(UFC_OFS_FUNCTION_ADDRESS_REG, {1'b0, adr});
    rd(UFC_OFS_FUNCTION_ADDRESS_REG, {1'b1, adr}, "address pending");
    @(negedge sys_clk);
    chk("address held", 8'h00, {1'b0, func_addr});
    u_host.pulse(0);
    @(negedge sys_clk);
    chk("address active", {1'b0, adr}, {1'b0, func_addr});
    rd(UFC_OFS_FUNCTION_ADDRESS_REG, {1'b0, adr}, "address in force");
  endtask
  // Read data is compared half a cycle after it lands
  always @(posedge sys_clk) rd_d <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_d && exp_q.size() > 0) begin
      chk(name_q.pop_front(), exp_q.pop_front(), reg_rdata);
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog: the sequence needs well under a few hundred cycles
  initial begin
    #(40 * 3000);
    err_count++;
    results();
  end
  initial begin
    reg_addr <= 6'h00;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_wdata <= 8'h00;
    ep_is_iso <= 3'h7;
    ep_pkt_loaded <= 3'h0;
    void'($urandom(32'h066f0687));
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    wr(UFC_OFS_POWER, 8'h08);
    rd(UFC_OFS_POWER, 8'h10, "power reset value");
    rd(UFC_OFS_IRQ_EN, 8'h0e, "enable reset value");
    wr(6'h3f, 8'hff);
    rd(6'h3f, 8'h00, "unmapped read");
    wr(UFC_OFS_IRQ_EN, 8'h0f);
    wr(UFC_OFS_POWER, 8'h11);
    wr(UFC_OFS_POWER, 8'h01);
    wr(UFC_OFS_POWER, 8'h11);
    rd(UFC_OFS_POWER, 8'h01, "power enabled");
    u_host.pulse(3);
    @(negedge sys_clk);
    chk("suspend entered", 8'h01, {7'h0, suspended});
    rd(UFC_OFS_POWER, 8'h03, "suspend status");
    rd(UFC_OFS_IRQ_FLAG, 8'h01, "suspend flag");
    rd(UFC_OFS_IRQ_FLAG, 8'h00, "flags after read");
    @(negedge sys_clk);
    chk("no events", 8'h00, {7'h0, event_pending});
    u_host.pulse(2);
    rd(UFC_OFS_POWER, 8'h01, "resume exit");
    rd(UFC_OFS_IRQ_FLAG, 8'h02, "resume flag");
    u_host.pulse(3);
    wr(UFC_OFS_POWER, 8'h05);
    rd(UFC_OFS_POWER, 8'h05, "wakeup drive");
    wr(UFC_OFS_POWER, 8'h01);
    @(negedge sys_clk);
    chk("wakeup stopped", 8'h00, {7'h0, resume_drive});
    addr_step();
    wr(UFC_OFS_IRQ_EN, 8'h01);
    u_host.pulse(3);
    u_host.hold_reset(1'b1);
    @(negedge sys_clk);
    chk("fifo flush", 8'h01, {7'h0, fifo_flush});
    chk("endpoint clear", 8'h01, {7'h0, ep_regs_clear});
    rd(UFC_OFS_POWER, 8'h09, "bus reset live");
    rd(UFC_OFS_IRQ_FLAG, 8'h04, "reset flag only");
    rd(UFC_OFS_IRQ_EN, 8'h0f, "enables after bus reset");
    rd(UFC_OFS_FUNCTION_ADDRESS_REG, 8'h00, "address cleared");
    u_host.hold_reset(1'b0);
    rd(UFC_OFS_POWER, 8'h01, "bus reset gone");
    wr(UFC_OFS_POWER, 8'h81);
    i = $urandom % 3;
    iso = 3'($urandom) | 3'(1 << i);
    @(posedge sys_clk);
    ep_is_iso <= iso;
    ep_pkt_loaded <= 3'h7;
    @(posedge sys_clk);
    ep_pkt_loaded <= 3'h0;
    @(negedge sys_clk);
    chk("iso held", {5'h0, iso}, {5'h0, ep_tx_hold});
    tok(2'(i + 1), 1'b1);
    tok(2'((i + 1) % 3 + 1), iso[(i + 1) % 3]);
    u_host.pulse(1);
    @(negedge sys_clk);
    chk("iso released", 8'h00, {5'h0, ep_tx_hold});
    rd(UFC_OFS_IRQ_FLAG, 8'h08, "frame flag");
    tok(2'(i + 1), 1'b0);
    addr_step();
    wr(UFC_OFS_POWER, 8'h08);
    @(negedge sys_clk);
    chk("soft reset pulse", 8'h00, {7'h0, usb_rst_n});
    rd(UFC_OFS_POWER, 8'h10, "power after soft reset");
    rd(UFC_OFS_IRQ_EN, 8'h0e, "enables after soft reset");
    @(negedge sys_clk);
    chk("address after soft reset", 8'h00, {1'b0, func_addr});
    chk("inhibit after soft reset", 8'h00, {7'h0, block_enabled});
    results();
  end
endmodule
`default_nettype wire

/* File: verif/ufc_top_monitor.sv */
`default_nettype none
module ufc_top_monitor
  import ufc_pkg::*;
#(
  parameter int N_EP = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  // Bus events
  input wire logic bus_reset_det,
  input wire logic suspend_det,
  input wire logic resume_det,
  input wire logic sof_pulse,
  input wire logic xfer_done,
  // Iso endpoints
  input wire logic [N_EP-1:0] ep_is_iso,
  input wire logic [N_EP-1:0] ep_pkt_loaded,
  input wire logic in_token,
  input wire logic [1:0] in_token_ep,
  input wire logic [N_EP-1:0] ep_tx_hold,
  input wire logic send_zlp,
  // Device state and side effects
  input wire logic [UFC_FA_W-1:0] func_addr,
  input wire logic block_enabled,
  input wire logic suspended,
  input wire logic resume_drive,
  input wire logic fifo_flush,
  input wire logic ep_regs_clear,
  input wire logic usb_rst_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Device side relations, one clock domain
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Address moves only on transfer end, bus reset or block reset
  property p_addr_waits;
    !xfer_done && !bus_reset_det && usb_rst_n ##1 usb_rst_n |-> $stable(func_addr);
  endproperty
  a_addr_waits: assert property (p_addr_waits) else $error("address moved early");
  property p_addr_zero;
    $rose(bus_reset_det) |=> func_addr == '0;
  endproperty
  a_addr_zero: assert property (p_addr_zero) else $error("address kept on bus reset");
  // Both side-effect pulses mark exactly the start of a bus reset
  property p_flush;
    fifo_flush == $rose(bus_reset_det) && ep_regs_clear == fifo_flush;
  endproperty
  a_flush: assert property (p_flush) else $error("flush pulse wrong");
  property p_susp_enter;
    $rose(suspended) |-> $past(suspend_det);
  endproperty
  a_susp_enter: assert property (p_susp_enter) else $error("suspend without cause");
  property p_susp_exit;
    suspended && (resume_det || bus_reset_det || resume_drive) |=> !suspended;
  endproperty
  a_susp_exit: assert property (p_susp_exit) else $error("suspend not left");
  // Reset may land one edge after the strobe, so either cycle counts
  property p_inhibit;
    $fell(block_enabled) |-> !usb_rst_n || !$past(usb_rst_n);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit set by software");
  property p_iso_hold;
    (ep_tx_hold & ~$past(ep_tx_hold) & ~$past(ep_pkt_loaded & ep_is_iso)) == '0;
  endproperty
  a_iso_hold: assert property (p_iso_hold) else $error("hold without load");
  property p_sof_release;
    sof_pulse && ep_pkt_loaded == '0 |=> ep_tx_hold == '0;
  endproperty
  a_sof_release: assert property (p_sof_release) else $error("hold kept past frame");
  property p_zlp;
    send_zlp |-> in_token && in_token_ep != 2'd0 && ep_tx_hold[in_token_ep - 2'd1];
  endproperty
  a_zlp: assert property (p_zlp) else $error("empty packet without hold");
  property p_wakeup;
    $rose(resume_drive) |-> $past(reg_wr && reg_addr == UFC_OFS_POWER && reg_wdata[2]);
  endproperty
  a_wakeup: assert property (p_wakeup) else $error("resume drive without write");
endmodule
bind ufc_top ufc_top_monitor #(.N_EP(N_EP)) u_mon (.sys_clk, .arst_n, .reg_addr, .reg_wr,
  .reg_wdata, .bus_reset_det, .suspend_det, .resume_det, .sof_pulse, .xfer_done, .ep_is_iso,
  .ep_pkt_loaded, .in_token, .in_token_ep, .ep_tx_hold, .send_zlp, .func_addr, .block_enabled,
  .suspended, .resume_drive, .fifo_flush, .ep_regs_clear, .usb_rst_n);
`default_nettype wire
